// >>> pkg/wmto_pkg.sv
// Types shared by the warning and tuning object block.
package wmto_pkg;
  typedef logic [15:0] wmto_word_t;
  typedef enum logic [1:0] {WMTO_AX_IDLE, WMTO_AX_RESP} wmto_wst_e;
endpackage : wmto_pkg

// >>> pkg/wmto_regs.svh
// Register offsets, field positions, reset values and timing counts of the warning block.
`ifndef WMTO_REGS_SVH
`define WMTO_REGS_SVH
// Printed offsets such as 3635h are not multiples of four, so they are indices; byte address = 4 * index.
`define WMTO_IDX_GAIN 16'h3634
`define WMTO_IDX_FILTER 16'h3635
`define WMTO_IDX_VTHR 16'h3637
`define WMTO_IDX_MASK 16'h3638
`define WMTO_IDX_DISP 16'h3700
`define WMTO_IDX_WSTAT 16'h3639
`define WMTO_IDX_ISTAT 16'h363a
`define WMTO_IDX_IMASK 16'h363b
`define WMTO_IDX_CFG 16'h363c
`define WMTO_IDX_DISPVAL 16'h3701
`define WMTO_RST_GAIN 16'h0000
`define WMTO_RST_FILTER 16'h000a
`define WMTO_RST_VTHR 16'h0000
`define WMTO_RST_MASK 16'h0004
`define WMTO_RST_DISP 16'h0000
`define WMTO_RST_CFG 16'h0303
`define WMTO_MAX_GAIN 16'h7530
`define WMTO_MAX_FILTER 16'h1900
`define WMTO_MAX_VTHR 16'h03e8
`define WMTO_MAX_DISP 16'h7fff
`define WMTO_RATIO_LIMIT 8'h55
`define WMTO_BIT_BATT 0
`define WMTO_BIT_LIFE 2
`define WMTO_BIT_ENCHOT 3
`define WMTO_BIT_ENCCOM 4
`define WMTO_BIT_REGEN 5
`define WMTO_BIT_FAN 6
`define WMTO_BIT_OVLD 7
`define WMTO_BIT_EXTENC 8
`define WMTO_BIT_VIB 9
`define WMTO_BIT_EXTCOM 10
`define WMTO_CFG_ENC_LSB 0
`define WMTO_CFG_EXT_LSB 8
`define WMTO_FAN_TIME_MS 1000
`define WMTO_CLK_MHZ 100
`define WMTO_FAN_CYCLES (`WMTO_FAN_TIME_MS * 1000 * `WMTO_CLK_MHZ)
`define WMTO_ERRCNT_MAX 16'hffff
`define WMTO_ANGLE_MAX 8'hff
`endif

// >>> src/wmto_core.sv
// Warning supervision, tuning objects and AXI4-Lite register slave.
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "wmto_regs.svh"

module wmto_core #(
  parameter int unsigned FAN_CYCLES = `WMTO_FAN_CYCLES
) (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rstn,
  // AXI4-Lite slave.
  input wire logic [17:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [17:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  // Drive condition inputs, asynchronous to the clock.
  input wire logic [7:0] i_load_ratio,
  input wire logic [7:0] i_regen_ratio,
  input wire logic i_battery_low,
  input wire logic i_fan_stopped,
  input wire logic i_enc_comm_err,
  input wire logic i_enc_overheat,
  input wire logic [15:0] i_torque_vib,
  input wire logic i_life_short,
  input wire logic i_ext_enc_warn,
  input wire logic i_ext_comm_err,
  input wire logic i_fully_closed,
  input wire logic [7:0] i_mech_angle,
  input wire logic [7:0] i_elec_angle,
  input wire logic [7:0] i_node_addr,
  input wire logic [7:0] i_zphase,
  // Results.
  output logic [15:0] o_warn,
  output logic o_irq,
  output logic [15:0] o_gain_applied,
  output logic [15:0] o_filter_time,
  output logic [7:0] o_display
);
  import wmto_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  localparam int NSYNC = 56;
  localparam logic [31:0] FAN_LAST = 32'(FAN_CYCLES - 1);

  typedef struct packed {
    logic [NSYNC-1:0] s1;
    logic [NSYNC-1:0] s2;
    logic enc_err_d;
    logic ext_err_d;
    logic aw_got;
    logic w_got;
    logic [15:0] aw_idx;
    logic [31:0] wd;
    logic [3:0] ws;
    wmto_wst_e wst;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic awrdy;
    logic wrdy;
    logic arrdy;
    wmto_word_t gain;
    wmto_word_t filter;
    wmto_word_t vthr;
    wmto_word_t mask;
    wmto_word_t disp;
    wmto_word_t cfg;
    wmto_word_t imask;
    wmto_word_t istat;
    wmto_word_t warn;
    logic irq;
    logic [31:0] fan_cnt;
    wmto_word_t enc_run;
    wmto_word_t ext_run;
    wmto_word_t enc_tot;
    wmto_word_t ext_tot;
    wmto_word_t gain_out;
    wmto_word_t filt_out;
    logic [7:0] dout;
  } wmto_state_s;

  wmto_state_s st_r;
  wmto_state_s st_nxt;

  ////////////////////////////////////////////////////////////////////////////////
  // Every pin input passes two flops before any logic looks at it.
  logic [NSYNC-1:0] pin_in;
  assign pin_in = {i_load_ratio, i_regen_ratio, i_battery_low, i_fan_stopped, i_enc_comm_err,
                   i_enc_overheat, i_torque_vib, i_life_short, i_ext_enc_warn, i_ext_comm_err,
                   i_fully_closed, i_mech_angle, i_elec_angle};
  logic [7:0] load_s, regen_s, mech_s, elec_s;
  logic batt_s, fan_s, enc_s, hot_s, life_s, xw_s, xc_s, fc_s;
  logic [15:0] vib_s;
  assign {load_s, regen_s, batt_s, fan_s, enc_s, hot_s, vib_s, life_s, xw_s, xc_s, fc_s,
          mech_s, elec_s} = st_r.s2;

  // Node address and Z-phase count come in through their own two flop stages.
  logic [15:0] aux_s1_r, aux_s2_r;
  logic [7:0] node_latch_r;
  logic [1:0] node_age_r;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      aux_s1_r <= 16'h0000;
      aux_s2_r <= 16'h0000;
      node_latch_r <= 8'h00;
      node_age_r <= 2'h0;
    end else begin
      aux_s1_r <= {i_node_addr, i_zphase};
      aux_s2_r <= aux_s1_r;
      if (node_age_r != 2'h3) begin
        node_age_r <= node_age_r + 2'h1;
      end
      // The address is caught once both sync stages hold it, and ignores later switch changes.
      if (node_age_r == 2'h2) begin
        node_latch_r <= aux_s2_r[15:8];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  logic [15:0] cond;
  logic [15:0] ev_set;
  logic aw_fire, w_fire, wr_go, ar_fire;
  logic [15:0] ar_idx;
  logic [15:0] wval;
  logic wr_ok;

  function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] mx);
    clamp = (v > mx) ? mx : v;
  endfunction : clamp

  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = pin_in;
    st_nxt.s2 = st_r.s1;
    st_nxt.enc_err_d = enc_s;
    st_nxt.ext_err_d = xc_s;
    // Fan stop timer restarts whenever the fan turns again.
    if (!fan_s) begin
      st_nxt.fan_cnt = 32'h0;
    end else if (st_r.fan_cnt < FAN_LAST) begin
      st_nxt.fan_cnt = st_r.fan_cnt + 32'h1;
    end
    // Error inputs are one pulse per error; two clean samples in a row end the series.
    if (enc_s && !st_r.enc_err_d) begin
      st_nxt.enc_run = (st_r.enc_run == `WMTO_ERRCNT_MAX) ? st_r.enc_run : st_r.enc_run + 16'h1;
      st_nxt.enc_tot = (st_r.enc_tot == `WMTO_ERRCNT_MAX) ? st_r.enc_tot : st_r.enc_tot + 16'h1;
    end else if (!enc_s && st_r.enc_err_d) begin
      st_nxt.enc_run = st_r.enc_run;
    end
    if (xc_s && !st_r.ext_err_d) begin
      st_nxt.ext_run = (st_r.ext_run == `WMTO_ERRCNT_MAX) ? st_r.ext_run : st_r.ext_run + 16'h1;
      st_nxt.ext_tot = (st_r.ext_tot == `WMTO_ERRCNT_MAX) ? st_r.ext_tot : st_r.ext_tot + 16'h1;
    end
    if (!enc_s && !st_r.enc_err_d) begin
      st_nxt.enc_run = 16'h0;
    end
    if (!xc_s && !st_r.ext_err_d) begin
      st_nxt.ext_run = 16'h0;
    end

    cond = 16'h0000;
    cond[`WMTO_BIT_OVLD] = (load_s >= `WMTO_RATIO_LIMIT);
    cond[`WMTO_BIT_REGEN] = (regen_s >= `WMTO_RATIO_LIMIT);
    cond[`WMTO_BIT_BATT] = batt_s;
    cond[`WMTO_BIT_FAN] = fan_s && (st_r.fan_cnt == FAN_LAST);
    cond[`WMTO_BIT_ENCCOM] = (st_r.enc_run > {8'h00, st_r.cfg[7:0]});
    cond[`WMTO_BIT_ENCHOT] = hot_s;
    cond[`WMTO_BIT_VIB] = (vib_s > st_r.vthr);
    cond[`WMTO_BIT_LIFE] = life_s;
    cond[`WMTO_BIT_EXTENC] = xw_s;
    cond[`WMTO_BIT_EXTCOM] = (st_r.ext_run > {8'h00, st_r.cfg[15:8]});
    st_nxt.warn = cond & ~st_r.mask;
    ev_set = st_nxt.warn & ~st_r.warn;

    st_nxt.gain_out = fc_s ? st_r.gain : 16'h0000;
    st_nxt.filt_out = st_r.filter;
    unique case (st_r.disp)
      16'h0001: st_nxt.dout = mech_s;
      16'h0002: st_nxt.dout = elec_s;
      16'h0003: st_nxt.dout = st_r.ext_tot[7:0];
      16'h0004: st_nxt.dout = node_latch_r;
      16'h0005: st_nxt.dout = st_r.enc_tot[7:0];
      16'h0006: st_nxt.dout = st_r.ext_tot[7:0];
      16'h0007: st_nxt.dout = aux_s2_r[7:0];
      default: st_nxt.dout = 8'h00;
    endcase

    // AXI4-Lite write path: address and data taken in either order.
    aw_fire = i_awvalid && !st_r.aw_got && (st_r.wst == WMTO_AX_IDLE);
    w_fire = i_wvalid && !st_r.w_got && (st_r.wst == WMTO_AX_IDLE);
    if (aw_fire) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.aw_idx = i_awaddr[17:2];
    end
    if (w_fire) begin
      st_nxt.w_got = 1'b1;
      st_nxt.wd = i_wdata;
      st_nxt.ws = i_wstrb;
    end
    wr_go = st_r.aw_got && st_r.w_got && (st_r.wst == WMTO_AX_IDLE);
    wval = st_r.wd[15:0];
    wr_ok = 1'b1;
    st_nxt.istat = st_r.istat;
    if (wr_go) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got = 1'b0;
      st_nxt.wst = WMTO_AX_RESP;
      st_nxt.bvalid = 1'b1;
      // Partial strobes keep the untouched byte of a 16-bit object.
      unique case (st_r.aw_idx)
        `WMTO_IDX_GAIN: wval = {st_r.ws[1] ? st_r.wd[15:8] : st_r.gain[15:8],
                                st_r.ws[0] ? st_r.wd[7:0] : st_r.gain[7:0]};
        `WMTO_IDX_FILTER: wval = {st_r.ws[1] ? st_r.wd[15:8] : st_r.filter[15:8],
                                  st_r.ws[0] ? st_r.wd[7:0] : st_r.filter[7:0]};
        `WMTO_IDX_VTHR: wval = {st_r.ws[1] ? st_r.wd[15:8] : st_r.vthr[15:8],
                                st_r.ws[0] ? st_r.wd[7:0] : st_r.vthr[7:0]};
        `WMTO_IDX_MASK: wval = {st_r.ws[1] ? st_r.wd[15:8] : st_r.mask[15:8],
                                st_r.ws[0] ? st_r.wd[7:0] : st_r.mask[7:0]};
        `WMTO_IDX_DISP: wval = {st_r.ws[1] ? st_r.wd[15:8] : st_r.disp[15:8],
                                st_r.ws[0] ? st_r.wd[7:0] : st_r.disp[7:0]};
        `WMTO_IDX_CFG: wval = {st_r.ws[1] ? st_r.wd[15:8] : st_r.cfg[15:8],
                               st_r.ws[0] ? st_r.wd[7:0] : st_r.cfg[7:0]};
        `WMTO_IDX_IMASK: wval = {st_r.ws[1] ? st_r.wd[15:8] : st_r.imask[15:8],
                                 st_r.ws[0] ? st_r.wd[7:0] : st_r.imask[7:0]};
        `WMTO_IDX_ISTAT: wval = {st_r.ws[1] ? st_r.wd[15:8] : 8'h00,
                                 st_r.ws[0] ? st_r.wd[7:0] : 8'h00};
        default: wr_ok = (st_r.aw_idx == `WMTO_IDX_WSTAT) || (st_r.aw_idx == `WMTO_IDX_DISPVAL);
      endcase
      // Out-of-range values are clamped rather than refused so software sees a legal setting.
      unique case (st_r.aw_idx)
        `WMTO_IDX_GAIN: st_nxt.gain = clamp(wval, `WMTO_MAX_GAIN);
        `WMTO_IDX_FILTER: st_nxt.filter = clamp(wval, `WMTO_MAX_FILTER);
        `WMTO_IDX_VTHR: st_nxt.vthr = clamp(wval, `WMTO_MAX_VTHR);
        `WMTO_IDX_MASK: st_nxt.mask = wval;
        `WMTO_IDX_DISP: st_nxt.disp = clamp(wval, `WMTO_MAX_DISP);
        `WMTO_IDX_CFG: st_nxt.cfg = wval;
        `WMTO_IDX_IMASK: st_nxt.imask = wval;
        `WMTO_IDX_ISTAT: st_nxt.istat = st_r.istat & ~wval;
        default: st_nxt.istat = st_r.istat;
      endcase
      st_nxt.bresp = wr_ok ? 2'b00 : 2'b10;
    end
    // A new event wins over a clear in the same cycle.
    st_nxt.istat = st_nxt.istat | ev_set;
    if (st_r.bvalid && i_bready) begin
      st_nxt.bvalid = 1'b0;
      st_nxt.wst = WMTO_AX_IDLE;
    end
    st_nxt.irq = |(st_nxt.istat & ~st_nxt.imask);

    // AXI4-Lite read path: one read at a time, answered the cycle after acceptance.
    ar_fire = i_arvalid && !st_r.rvalid;
    ar_idx = i_araddr[17:2];
    if (ar_fire) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = 2'b00;
      st_nxt.rdata = 32'h0;
      unique case (ar_idx)
        `WMTO_IDX_GAIN: st_nxt.rdata[15:0] = st_r.gain;
        `WMTO_IDX_FILTER: st_nxt.rdata[15:0] = st_r.filter;
        `WMTO_IDX_VTHR: st_nxt.rdata[15:0] = st_r.vthr;
        `WMTO_IDX_MASK: st_nxt.rdata[15:0] = st_r.mask;
        `WMTO_IDX_DISP: st_nxt.rdata[15:0] = st_r.disp;
        `WMTO_IDX_WSTAT: st_nxt.rdata[15:0] = st_r.warn;
        `WMTO_IDX_ISTAT: st_nxt.rdata[15:0] = st_r.istat;
        `WMTO_IDX_IMASK: st_nxt.rdata[15:0] = st_r.imask;
        `WMTO_IDX_CFG: st_nxt.rdata[15:0] = st_r.cfg;
        `WMTO_IDX_DISPVAL: st_nxt.rdata[15:0] = {8'h00, st_r.dout};
        default: st_nxt.rresp = 2'b10;
      endcase
    end else if (st_r.rvalid && i_rready) begin
      st_nxt.rvalid = 1'b0;
    end
    // Ready outputs are registered copies of the acceptance conditions.
    st_nxt.awrdy = !st_nxt.aw_got && (st_nxt.wst == WMTO_AX_IDLE);
    st_nxt.wrdy = !st_nxt.w_got && (st_nxt.wst == WMTO_AX_IDLE);
    st_nxt.arrdy = !st_nxt.rvalid;
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_r <= '0;
      st_r.wst <= WMTO_AX_IDLE;
      st_r.filter <= `WMTO_RST_FILTER;
      st_r.mask <= `WMTO_RST_MASK;
      st_r.gain <= `WMTO_RST_GAIN;
      st_r.vthr <= `WMTO_RST_VTHR;
      st_r.disp <= `WMTO_RST_DISP;
      st_r.cfg <= `WMTO_RST_CFG;
      st_r.filt_out <= `WMTO_RST_FILTER;
      st_r.awrdy <= 1'b1;
      st_r.wrdy <= 1'b1;
      st_r.arrdy <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  assign o_awready = st_r.awrdy;
  assign o_wready = st_r.wrdy;
  assign o_bvalid = st_r.bvalid;
  assign o_bresp = st_r.bresp;
  assign o_arready = st_r.arrdy;
  assign o_rvalid = st_r.rvalid;
  assign o_rdata = st_r.rdata;
  assign o_rresp = st_r.rresp;
  assign o_warn = st_r.warn;
  assign o_irq = st_r.irq;
  assign o_gain_applied = st_r.gain_out;
  assign o_filter_time = st_r.filt_out;
  assign o_display = st_r.dout;

  ////////////////////////////////////////////////////////////////////////////////
  sequence s_ovld_seen;
    load_s >= `WMTO_RATIO_LIMIT;
  endsequence
  property p_mask_blocks;
    @(posedge i_clk) disable iff (!i_rstn) $past(st_r.mask[`WMTO_BIT_BATT]) |-> !o_warn[0];
  endproperty
  a_mask_blocks: assert property (p_mask_blocks) else $error("masked warning raised");
  property p_ovld;
    @(posedge i_clk) disable iff (!i_rstn)
      s_ovld_seen and !st_r.mask[7] |=> o_warn[7];
  endproperty
  a_ovld: assert property (p_ovld) else $error("overload warning missing");
  property p_regen;
    @(posedge i_clk) disable iff (!i_rstn)
      (regen_s < `WMTO_RATIO_LIMIT) |=> !o_warn[5];
  endproperty
  a_regen: assert property (p_regen) else $error("regeneration warning false");
  property p_batt;
    @(posedge i_clk) disable iff (!i_rstn) (batt_s && !st_r.mask[0]) |=> o_warn[0];
  endproperty
  a_batt: assert property (p_batt) else $error("battery warning missing");
  property p_fan;
    @(posedge i_clk) disable iff (!i_rstn) !fan_s |=> !o_warn[6];
  endproperty
  a_fan: assert property (p_fan) else $error("fan warning without stop");
  property p_vib;
    @(posedge i_clk) disable iff (!i_rstn) (vib_s <= st_r.vthr) |=> !o_warn[9];
  endproperty
  a_vib: assert property (p_vib) else $error("vibration warning below threshold");
  property p_gain;
    @(posedge i_clk) disable iff (!i_rstn) !fc_s |=> (o_gain_applied == 16'h0000);
  endproperty
  a_gain: assert property (p_gain) else $error("gain applied outside fully-closed");
  property p_filt;
    @(posedge i_clk) disable iff (!i_rstn) o_filter_time <= `WMTO_MAX_FILTER;
  endproperty
  a_filt: assert property (p_filt) else $error("filter time out of range");
  property p_status;
    @(posedge i_clk) disable iff (!i_rstn) ##1 (o_warn == ($past(cond) & ~$past(st_r.mask)));
  endproperty
  a_status: assert property (p_status) else $error("warning status mismatch");
endmodule : wmto_core
`default_nettype wire

// >>> testbench/tb_top.sv
// Self-checking testbench of the warning supervision and tuning object block.
`timescale 1ns/1ps
`default_nettype none
`include "wmto_regs.svh"
module tb_top;
  import wmto_pkg::*;
  // A short fan time keeps the run brief; every fan expectation derives from it.
  localparam int unsigned FAN = 20;
  logic i_clk, i_rstn, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
  logic [17:0] i_awaddr, i_araddr;
  logic [31:0] i_wdata, o_rdata, rd;
  logic [3:0] i_wstrb;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_irq;
  logic [1:0] o_bresp, o_rresp, rsp;
  logic [7:0] i_load_ratio, i_regen_ratio, i_mech_angle, i_elec_angle, i_node_addr, i_zphase;
  logic [7:0] o_display;
  logic i_battery_low, i_fan_stopped, i_enc_comm_err, i_enc_overheat, i_life_short;
  logic i_ext_enc_warn, i_ext_comm_err, i_fully_closed;
  logic [15:0] i_torque_vib, o_warn, o_gain_applied, o_filter_time;
  int failures, total_checks, cyc;
  int bits[7] = '{0, 2, 3, 5, 7, 8, 9};
  logic [7:0] dsel[8] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08};
  logic [7:0] dexp[8] = '{8'h5a, 8'ha5, 8'h04, 8'h05, 8'h04, 8'h04, 8'hc3, 8'h00};

  wmto_core #(.FAN_CYCLES(FAN)) u_wmto_core (
    .i_clk, .i_rstn, .i_awaddr, .i_awvalid, .o_awready, .i_wdata, .i_wstrb, .i_wvalid,
    .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid, .o_arready, .o_rdata,
    .o_rresp, .o_rvalid, .i_rready, .i_load_ratio, .i_regen_ratio, .i_battery_low,
    .i_fan_stopped, .i_enc_comm_err, .i_enc_overheat, .i_torque_vib, .i_life_short,
    .i_ext_enc_warn, .i_ext_comm_err, .i_fully_closed, .i_mech_angle, .i_elec_angle,
    .i_node_addr, .i_zphase, .o_warn, .o_irq, .o_gain_applied, .o_filter_time, .o_display);

  ////////////////////////////////////////////////////////////////////////////////////////////
  initial i_clk = 1'b0;
  always #5 i_clk = ~i_clk;

  task automatic conclude;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude

  // The ceiling of 8000 cycles sits well above the several hundred cycles that the scenarios need.
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      failures++;
      conclude();
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic cyc_wait(input int n);
    repeat (n) @(posedge i_clk);
  endtask : cyc_wait

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Each bus task starts on a fresh edge so that no strobe is assigned twice in one step.
  task automatic axw(input wmto_word_t idx, input wmto_word_t d);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge i_clk);
    i_awaddr <= {idx, 2'b00};
    i_wdata <= {16'h0000, d};
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge i_clk);
      if (i_awvalid && o_awready) begin
        aw_done = 1'b1;
        i_awvalid <= 1'b0;
      end
      if (i_wvalid && o_wready) begin
        w_done = 1'b1;
        i_wvalid <= 1'b0;
      end
    end
    do @(posedge i_clk); while (!o_bvalid);
    rsp = o_bresp;
    i_bready <= 1'b0;
  endtask : axw

  task automatic axr(input wmto_word_t idx);
    @(posedge i_clk);
    i_araddr <= {idx, 2'b00};
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    do @(posedge i_clk); while (!o_arready);
    i_arvalid <= 1'b0;
    do @(posedge i_clk); while (!o_rvalid);
    rd = o_rdata;
    rsp = o_rresp;
    i_rready <= 1'b0;
  endtask : axr

  task automatic rchk(input string name, input wmto_word_t idx, input logic [31:0] exp);
    axr(idx);
    check(name, rd, exp);
  endtask : rchk

  // Sets one warning condition just on or just off its documented boundary.
  task automatic drive(input int k, input logic on);
    case (k)
      0: i_battery_low <= on;
      2: i_life_short <= on;
      3: i_enc_overheat <= on;
      5: i_regen_ratio <= on ? 8'h55 : 8'h54;
      7: i_load_ratio <= on ? 8'h55 : 8'h54;
      8: i_ext_enc_warn <= on;
      default: i_torque_vib <= on ? 16'h0065 : 16'h0064;
    endcase
  endtask : drive

  // The line is left high, since two clean samples in a row end the error series.
  task automatic pulses(input logic ext, input int n);
    repeat (n) begin
      i_ext_comm_err <= 1'b0;
      i_enc_comm_err <= 1'b0;
      @(posedge i_clk);
      if (ext) i_ext_comm_err <= 1'b1;
      else i_enc_comm_err <= 1'b1;
      @(posedge i_clk);
    end
    cyc_wait(5);
  endtask : pulses

  ////////////////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    check("filter out", {16'h0000, o_filter_time}, 32'h0000000a);
    rchk("gain", `WMTO_IDX_GAIN, 32'h00000000);
    rchk("filter", `WMTO_IDX_FILTER, 32'h0000000a);
    rchk("threshold", `WMTO_IDX_VTHR, 32'h00000000);
    rchk("mask", `WMTO_IDX_MASK, 32'h00000004);
    rchk("display sel", `WMTO_IDX_DISP, 32'h00000000);
    rchk("cfg", `WMTO_IDX_CFG, 32'h00000303);
    axr(16'h0000);
    check("rresp unmapped", {30'h0, rsp}, 32'h00000002);
    axw(16'h0000, 16'h1234);
    check("bresp unmapped", {30'h0, rsp}, 32'h00000002);
    i_life_short <= 1'b1;
    cyc_wait(6);
    check("life masked", {16'h0000, o_warn}, 32'h00000000);
    i_life_short <= 1'b0;
    cyc_wait(6);
  endtask : t_reset

  task automatic t_limits;
    axw(`WMTO_IDX_GAIN, 16'h7531);
    rchk("gain clamp", `WMTO_IDX_GAIN, 32'h00007530);
    cyc_wait(5);
    check("gain open", {16'h0000, o_gain_applied}, 32'h00000000);
    i_fully_closed <= 1'b1;
    cyc_wait(5);
    check("gain closed", {16'h0000, o_gain_applied}, 32'h00007530);
    axw(`WMTO_IDX_FILTER, 16'h1901);
    rchk("filter clamp", `WMTO_IDX_FILTER, 32'h00001900);
    cyc_wait(2);
    check("filter out", {16'h0000, o_filter_time}, 32'h00001900);
    axw(`WMTO_IDX_VTHR, 16'h03e9);
    rchk("threshold clamp", `WMTO_IDX_VTHR, 32'h000003e8);
    axw(`WMTO_IDX_VTHR, 16'h0064);
    axw(`WMTO_IDX_CFG, (16'h0003 << 8) + (16'h0003 << 0));
  endtask : t_limits

  // The off value of every condition is the nearest one that must not warn.
  task automatic t_levels;
    axw(`WMTO_IDX_MASK, 16'h0000);
    foreach (bits[j]) begin
      drive(bits[j], 1'b1);
      cyc_wait(6);
      check("warn set", {16'h0000, o_warn}, 32'h1 << bits[j]);
      axw(`WMTO_IDX_MASK, 16'h0001 << bits[j]);
      cyc_wait(3);
      check("warn masked", {16'h0000, o_warn}, 32'h00000000);
      axw(`WMTO_IDX_MASK, 16'h0000);
      cyc_wait(3);
      check("warn unmasked", {16'h0000, o_warn}, 32'h1 << bits[j]);
      drive(bits[j], 1'b0);
      cyc_wait(6);
      check("warn clear", {16'h0000, o_warn}, 32'h00000000);
    end
  endtask : t_levels

  task automatic t_fan;
    i_fan_stopped <= 1'b1;
    cyc_wait(FAN - 8);
    i_fan_stopped <= 1'b0;
    cyc_wait(6);
    i_fan_stopped <= 1'b1;
    cyc_wait(FAN - 8);
    check("fan early", {16'h0000, o_warn}, 32'h00000000);
    cyc_wait(FAN);
    check("fan late", {16'h0000, o_warn}, 32'h00000040);
    i_fan_stopped <= 1'b0;
    cyc_wait(6);
  endtask : t_fan

  task automatic t_count;
    pulses(1'b0, 3);
    check("enc at limit", {16'h0000, o_warn & 16'h0010}, 32'h00000000);
    pulses(1'b0, 1);
    check("enc past limit", {16'h0000, o_warn & 16'h0010}, 32'h00000010);
    i_enc_comm_err <= 1'b0;
    cyc_wait(8);
    check("enc series end", {16'h0000, o_warn & 16'h0010}, 32'h00000000);
    pulses(1'b1, 3);
    check("ext at limit", {16'h0000, o_warn & 16'h0400}, 32'h00000000);
    pulses(1'b1, 1);
    check("ext past limit", {16'h0000, o_warn & 16'h0400}, 32'h00000400);
    i_ext_comm_err <= 1'b0;
    cyc_wait(8);
    check("ext series end", {16'h0000, o_warn & 16'h0400}, 32'h00000000);
  endtask : t_count

  task automatic t_display;
    foreach (dsel[j]) begin
      axw(`WMTO_IDX_DISP, {8'h00, dsel[j]});
      cyc_wait(5);
      check("display", {24'h0, o_display}, {24'h0, dexp[j]});
    end
  endtask : t_display

  task automatic t_irq;
    axw(`WMTO_IDX_IMASK, 16'h0000);
    axw(`WMTO_IDX_ISTAT, 16'hffff);
    cyc_wait(2);
    check("irq idle", {31'h0, o_irq}, 32'h00000000);
    drive(0, 1'b1);
    cyc_wait(6);
    check("irq raised", {31'h0, o_irq}, 32'h00000001);
    axw(`WMTO_IDX_IMASK, 16'h0001);
    cyc_wait(2);
    check("irq masked", {31'h0, o_irq}, 32'h00000000);
    axw(`WMTO_IDX_IMASK, 16'h0000);
    drive(0, 1'b0);
    cyc_wait(6);
    check("irq sticky", {31'h0, o_irq}, 32'h00000001);
    axw(`WMTO_IDX_ISTAT, 16'h0001);
    cyc_wait(2);
    check("irq cleared", {31'h0, o_irq}, 32'h00000000);
    rchk("irq status", `WMTO_IDX_ISTAT, 32'h00000000);
  endtask : t_irq

  ////////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    i_rstn = 1'b0;
    {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 5'h00;
    i_awaddr = 18'h00000;
    i_araddr = 18'h00000;
    i_wdata = 32'h00000000;
    i_wstrb = 4'h3;
    {i_load_ratio, i_regen_ratio} = 16'h0000;
    {i_battery_low, i_fan_stopped, i_enc_comm_err, i_enc_overheat} = 4'h0;
    {i_life_short, i_ext_enc_warn, i_ext_comm_err, i_fully_closed} = 4'h0;
    i_torque_vib = 16'h0000;
    i_mech_angle = 8'h5a;
    i_elec_angle = 8'ha5;
    i_node_addr = 8'h05;
    i_zphase = 8'hc3;
    cyc_wait(2);
    i_rstn <= 1'b1;
    t_reset();
    t_limits();
    t_levels();
    t_fan();
    t_count();
    t_display();
    t_irq();
    conclude();
  end
endmodule : tb_top
`default_nettype wire
